// ---- src/delay_ctrl_cfg.svh ----
// Purpose: timing constants for the delay line controller
// Assumes: 50 MHz mclk, 20 ns period
// Notes:   times in ns, counts derived by rounding up
`ifndef DELAY_CTRL_CFG_SVH
`define DELAY_CTRL_CFG_SVH

`define CLK_PERIOD_NS      20
`define STEP_INCREMENT_NS  100
`define STEP_CYCLES        ((`STEP_INCREMENT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INHERENT_LATENCY_NS 6
`define LATENCY_CYCLES     ((`INHERENT_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CODE_WIDTH         4
`define CODE_MAX           15
`define PERIOD_PCT         200
`define WIDTH_PCT          100

`endif

// ---- src/delay_ctrl_pkg.sv ----
// Purpose: types for the delay line controller
// Assumes: nothing
// Notes:   state encoding left to the tool
package delay_ctrl_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_drain,
    st_settle,
    st_clear,
    st_run
  } ctrl_state_type;
endpackage

// ---- src/delay_line_ctrl.sv ----
// Purpose: controller that drives a 4-bit programmable delay line
// Assumes: pulse source and returned delayed output are synchronous to mclk
// Notes:   all waits are counted in whole mclk cycles, rounded up
`timescale 1ns/1ps
`default_nettype none
`include "delay_ctrl_cfg.svh"

// What this block does
// - disable held low normally; high forces the delayed output low
// - select code held steady while delayed pulses are expected
// - code change waits max(new-old,0) steps after last output edge
// - on disable hold disable high, source low for code times step
// - recommended period 200 percent, width 100 percent of total delay
// - suggested period 40 percent, width 20 percent of total delay
// - absolute period 16 percent, width 8 percent of total delay
module delay_line_ctrl
#(
  parameter int CODE_WIDTH  = `CODE_WIDTH,
  parameter int STEP_CYCLES = `STEP_CYCLES,
  parameter int WAIT_WIDTH  = 12
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      enable_req,
  input  wire logic [CODE_WIDTH-1:0]     new_code,
  input  wire logic                      code_load,
  input  wire logic                      pulse_req,
  input  wire logic                      delayed_result,
  output logic [CODE_WIDTH-1:0]          delay_select,
  output logic                           output_disable,
  output logic                           delayed_source,
  output logic                           busy,
  output delay_ctrl_pkg::ctrl_state_type state
);
  import delay_ctrl_pkg::*;

  localparam int TOTAL_CYCLES = STEP_CYCLES * `CODE_MAX + `LATENCY_CYCLES;
  localparam int WIDTH_CYCLES = (TOTAL_CYCLES * `WIDTH_PCT + 99) / 100;
  localparam int PERIOD_CYCLES = (TOTAL_CYCLES * `PERIOD_PCT + 99) / 100;

  // ==========================================================
  // control state
  ctrl_state_type        state_q;
  ctrl_state_type        state_d;
  logic [CODE_WIDTH-1:0] code_q;
  logic [CODE_WIDTH-1:0] code_d;
  logic [CODE_WIDTH-1:0] pend_q;
  logic [CODE_WIDTH-1:0] pend_d;
  logic                  dis_q;
  logic                  dis_d;
  logic                  src_q;
  logic                  src_d;
  logic [WAIT_WIDTH-1:0] pcnt_q;
  logic [WAIT_WIDTH-1:0] pcnt_d;
  logic                  prev_out_q;
  logic                  wait_load;
  logic [WAIT_WIDTH-1:0] wait_value;
  logic                  wait_done;
  logic                  out_edge;

  wait_counter #(
    .WIDTH(WAIT_WIDTH)
  ) u_wait (
    .mclk      (mclk),
    .rst       (rst),
    .load      (wait_load),
    .load_value(wait_value),
    .done      (wait_done)
  );

  // ==========================================================
  // sequencing
  always_comb
  begin
    state_d    = state_q;
    code_d     = code_q;
    pend_d     = pend_q;
    dis_d      = dis_q;
    src_d      = src_q;
    pcnt_d     = pcnt_q;
    wait_load  = 1'b0;
    wait_value = '0;
    out_edge   = (delayed_result != prev_out_q);
    if (pcnt_q != '0)
    begin
      pcnt_d = pcnt_q - 1'b1;
    end
    // the last output edge restarts the drain so the wait counts from it
    if (out_edge && state_q == st_drain)
    begin
      wait_load  = 1'b1;
      wait_value = WAIT_WIDTH'(TOTAL_CYCLES);
    end
    unique case (state_q)
      st_idle:
      begin
        src_d = 1'b0;
        if (code_load)
        begin
          pend_d  = new_code;
          state_d = st_drain;
          wait_load  = 1'b1;
          wait_value = WAIT_WIDTH'(TOTAL_CYCLES);
        end
        else if (enable_req)
        begin
          dis_d   = 1'b0;
          state_d = st_run;
        end
      end
      st_run:
      begin
        // pulse shaping keeps width and period at recommended figures
        // loaded one short so high and low spans are exactly the counts
        if (pcnt_q == '0 && pulse_req)
        begin
          src_d  = 1'b1;
          pcnt_d = WAIT_WIDTH'(PERIOD_CYCLES - 1);
        end
        else if (pcnt_q == WAIT_WIDTH'(PERIOD_CYCLES - WIDTH_CYCLES))
        begin
          src_d = 1'b0;
        end
        // a code change goes through clear first, so the line empties first
        if (!enable_req || code_load)
        begin
          pend_d     = code_load ? new_code : code_q;
          dis_d      = 1'b1;
          src_d      = 1'b0;
          state_d    = st_clear;
          wait_load  = 1'b1;
          wait_value = WAIT_WIDTH'(int'(code_q) * STEP_CYCLES + 1);
        end
      end
      st_clear:
      begin
        src_d = 1'b0;
        dis_d = 1'b1;
        if (wait_done)
        begin
          state_d = (pend_q != code_q) ? st_drain : st_idle;
          if (pend_q != code_q)
          begin
            wait_load  = 1'b1;
            wait_value = WAIT_WIDTH'(TOTAL_CYCLES);
          end
        end
      end
      st_drain:
      begin
        // an output edge in the last cycle of the wait restarts it instead
        if (wait_done && !out_edge)
        begin
          state_d   = st_settle;
          wait_load = 1'b1;
          // waiting only matters when the code grows
          if (pend_q > code_q)
          begin
            wait_value = WAIT_WIDTH'(int'(pend_q - code_q) * STEP_CYCLES + 1);
          end
          else
          begin
            wait_value = WAIT_WIDTH'(1);
          end
        end
      end
      st_settle:
      begin
        if (wait_done)
        begin
          code_d  = pend_q;
          state_d = st_idle;
        end
      end
      default:
      begin
        state_d = st_idle;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= st_idle;
      code_q     <= '0;
      pend_q     <= '0;
      dis_q      <= 1'b1;
      src_q      <= 1'b0;
      pcnt_q     <= '0;
      prev_out_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      code_q     <= code_d;
      pend_q     <= pend_d;
      dis_q      <= dis_d;
      src_q      <= src_d;
      pcnt_q     <= pcnt_d;
      prev_out_q <= delayed_result;
    end
  end

  // ==========================================================
  // outputs
  // code is only changed in st_settle, so it is steady while running
  assign delay_select   = code_q;
  assign output_disable = dis_q;
  assign delayed_source = src_q;
  assign busy           = (state_q != st_run) && (state_q != st_idle);
  assign state          = state_q;
endmodule
`default_nettype wire

// ---- src/wait_counter.sv ----
// Purpose: loadable down counter that flags when a wait has run out
// Assumes: load has priority over counting
// Notes:   done is high whenever the count is zero
`timescale 1ns/1ps
`default_nettype none
module wait_counter #(
  parameter int WIDTH = 12
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  done
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  always_comb
  begin
    count_d = count_q;
    if (load)
    begin
      count_d = load_value;
    end
    else if (count_q != '0)
    begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign done = (count_q == '0);
endmodule
`default_nettype wire

// ---- tb/delay_ctrl_properties.sv ----
// Purpose: pin timing checks for delay_line_ctrl
// Assumes: one clock, total delay of 15 steps plus 1
// Notes:   pulse limits counted in mclk cycles
`timescale 1ns/1ps
`default_nettype none
// ====
// checks
module delay_ctrl_properties #(
  parameter int STEP_CYCLES = 5
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       delayed_result,
  input wire logic [3:0] delay_select,
  input wire logic       output_disable,
  input wire logic       delayed_source
);
  localparam int TOT = 15 * STEP_CYCLES + 1;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic [7:0] per_q;
  logic [7:0] per_d;
  logic       src_q;
  always_comb
  begin
    hi_d  = delayed_source ? hi_q + 8'h01 : 8'h00;
    per_d = (delayed_source && !src_q) ? 8'h01 : per_q + {7'h0, per_q != 8'hff};
  end
  // saturating start lets the first pulse after reset pass
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      hi_q  <= 8'h00;
      per_q <= 8'hff;
      src_q <= 1'b0;
    end
    else
    begin
      hi_q  <= hi_d;
      per_q <= per_d;
      src_q <= delayed_source;
    end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sel_steady_a: assert property ($changed(delay_select) |-> output_disable)
    else $error("code moved while enabled");
  src_low_a: assert property (output_disable |-> !delayed_source)
    else $error("source high while disabled");
  edge_wait_a: assert property ($changed(delayed_result) |=> $stable(delay_select)[*8])
    else $error("code moved soon after output edge");
  clear_hold_a: assert property ($rose(output_disable) && delay_select != 4'h0 |->
    (output_disable && !delayed_source)[*5]) else $error("clear hold cut short");
  width_rec_a: assert property ($fell(delayed_source) && !output_disable |-> hi_q >= TOT)
    else $error("pulse too narrow");
  period_rec_a: assert property ($rose(delayed_source) |-> per_q >= 2 * TOT)
    else $error("period too short");
  period_sug_a: assert property ($rose(delayed_source) |-> per_q >= (2 * TOT + 4) / 5)
    else $error("period below suggested");
  width_abs_a: assert property ($fell(delayed_source) && !output_disable |->
    hi_q >= (2 * TOT + 24) / 25) else $error("pulse below absolute");
  cover property ($rose(delayed_source));
  cover property ($changed(delay_select));
  cover property ($rose(output_disable) && delay_select != 4'h0);
endmodule
bind delay_line_ctrl delay_ctrl_properties #(.STEP_CYCLES(STEP_CYCLES)) u_props (.mclk(mclk),
  .rst(rst), .delayed_result(delayed_result), .delay_select(delay_select),
  .output_disable(output_disable), .delayed_source(delayed_source));
`default_nettype wire

// ---- tb/delay_line_model.sv ----
// Purpose: behavioural delay line seen by the controller
// Assumes: times in ns
// Notes:   no drift with rate, so any delay shift is constant
`timescale 1ns/1ps
`default_nettype none
module delay_line_model #(
  parameter int LAT_NS  = 6,
  parameter int STEP_NS = 100
) (
  input  wire logic       delayed_source,
  input  wire logic [3:0] delay_select,
  input  wire logic       output_disable,
  output logic            delayed_result
);
  logic line_q = 1'b0;
  // code taken as the edge enters; a later code leaves it in flight as is
  always @(delayed_source)
    line_q <= #(LAT_NS + STEP_NS * delay_select) delayed_source;
  assign delayed_result = line_q & ~output_disable;
endmodule
`default_nettype wire

// ---- tb/tb_delay_line_ctrl.sv ----
// Purpose: directed bench for delay_line_ctrl
// Assumes: 50 MHz mclk, model stands in for the line
// Notes:   total delay 76 cycles, period 152
`timescale 1ns/1ps
`default_nettype none
module tb_delay_line_ctrl;
  import delay_ctrl_pkg::*;
  logic           mclk = 1'b0, rst = 1'b1, enable_req = 1'b0, code_load = 1'b0;
  logic           pulse_req = 1'b0, output_disable, delayed_source, delayed_result, busy;
  logic [3:0]     new_code = 4'h0, delay_select;
  ctrl_state_type state;
  int             fails = 0, n_compared = 0, n;
  delay_line_ctrl DUT (.mclk(mclk), .rst(rst), .enable_req(enable_req), .new_code(new_code),
    .code_load(code_load), .pulse_req(pulse_req), .delayed_result(delayed_result),
    .delay_select(delay_select), .output_disable(output_disable),
    .delayed_source(delayed_source), .busy(busy), .state(state));
  delay_line_model u_line (.delayed_source(delayed_source), .delay_select(delay_select),
    .output_disable(output_disable), .delayed_result(delayed_result));
  initial
    forever #10 mclk = ~mclk;
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: got %0h want %0h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded waits, n holds the cycles spent
  task automatic to_idle;
    n = 0;
    while (state !== st_idle && n < 2000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 2000)
    begin
      fails++;
      $display("Error %0t: wait for idle ran out", $time);
    end
  endtask
  task automatic hold(input logic v);
    n = 0;
    while (delayed_source === v && n < 400)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task automatic t_reset;
    chk({6'h0, delay_select, output_disable, delayed_source}, 12'h002);
  endtask
  task automatic t_code(input logic [3:0] c, input int lo);
    @(posedge mclk);
    new_code  <= c;
    code_load <= 1'b1;
    @(posedge mclk);
    code_load <= 1'b0;
    #1;
    chk({11'h0, busy}, 12'h001);
    to_idle();
    chk({11'h0, n >= lo}, 12'h001);
    chk({8'h0, delay_select}, {8'h0, c});
  endtask
  task automatic t_run(input logic [3:0] c);
    @(posedge mclk);
    enable_req <= 1'b1;
    pulse_req  <= 1'b1;
    hold(1'b0);
    chk({11'h0, output_disable}, 12'h000);
    hold(1'b1);
    chk(12'(n), 12'h04c);
    hold(1'b0);
    chk(12'(n), 12'h04c);
    @(posedge mclk);
    enable_req <= 1'b0;
    @(posedge mclk);
    #1;
    chk({10'h0, output_disable, delayed_source}, 12'h002);
    to_idle();
    chk({11'h0, n >= 5 * c}, 12'h001);
  endtask
  initial
  begin
    #400000;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_code(4'h3, 91);
    t_run(4'h3);
    @(posedge mclk);
    enable_req <= 1'b1;
    repeat (300) @(posedge mclk);
    t_code(4'h0, 91);
    @(posedge mclk);
    enable_req <= 1'b0;
    @(posedge mclk);
    #1;
    to_idle();
    t_code(4'hf, 151);
    t_run(4'hf);
    summarize();
  end
endmodule
`default_nettype wire
